// file: ftw_pkg.sv
// Constants shared by the fan tachometer and temperature watchdog block.
package ftw_pkg;
  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_HZ       = 40_000_000;
  localparam int OSC_HZ       = 22_500;
  // The base tick runs at twice the nominal rate; the divisor then
  // prescales it, so the default divisor of 2 counts at 22.5 kHz.
  localparam int TICK_CYC     = CLK_HZ / (2 * OSC_HZ);
  localparam int RST_PULSE_MS = 10;
  localparam int RST_PULSE_CYC = CLK_HZ / 1000 * RST_PULSE_MS;
  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] A_CTL   = 8'h00;
  localparam logic [7:0] A_ISR1  = 8'h01;
  localparam logic [7:0] A_ISR2  = 8'h02;
  localparam logic [7:0] A_FDIV  = 8'h05;
  localparam logic [7:0] A_OCFG  = 8'h06;
  localparam logic [7:0] A_TEMP  = 8'h27;
  localparam logic [7:0] A_TACH_INPUT_FIRST  = 8'h28;
  localparam logic [7:0] A_TACH_INPUT_SECOND  = 8'h29;
  localparam logic [7:0] A_HOT   = 8'h38;
  localparam logic [7:0] A_HOTH  = 8'h39;
  localparam logic [7:0] A_OS    = 8'h3A;
  localparam logic [7:0] A_OSH   = 8'h3B;
  localparam logic [7:0] A_FLIM1 = 8'h3C;
  localparam logic [7:0] A_FLIM2 = 8'h3D;
  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] CTL_RST  = 8'h08;
  localparam logic [7:0] FDIV_RST = 8'h14;
  localparam logic [7:0] OCFG_RST = 8'h00;
  localparam logic [7:0] LIM_RST  = 8'h7F;
  localparam logic [7:0] FLIM_RST = 8'hFF;
  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int CTL_START = 0;
  localparam int CTL_INTEN = 1;
  localparam int CTL_POL   = 2;
  localparam int CTL_ICLR  = 3;
  localparam int CTL_RESET = 4;
  localparam int FD_MODE0  = 0;
  localparam int FD_DIV0   = 2;
  localparam int FD_OSEN   = 6;
  localparam int FD_RSTEN  = 7;
  localparam int OC_STAT1T = 1;
  localparam int OC_OS1T   = 2;
  localparam int OC_RES12  = 3;
  localparam int ISR1_HOT  = 4;
  localparam int ISR1_FAN0 = 6;
  localparam int ISR2_FAN0 = 2;
  localparam int ISR2_OS   = 5;
endpackage

// file: ftw_tach.sv
// Tachometer period counter for one fan channel.
module ftw_tach (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  // Timebase and fan
  input  wire logic       tick_in,
  input  wire logic       tach_in,
  input  wire logic [1:0] div_sel_in,
  // Result
  output logic [7:0]      count_out,
  output logic            done_out
);
  typedef struct packed {
    logic       tach_q;
    logic       meas;
    logic [2:0] pre;
    logic [7:0] cnt;
    logic [7:0] res;
    logic       done;
  } ftw_tach_st_t;

  // The tach line idles high behind its pull-up, so the edge detector
  // starts high; a low reset value would fake a period start.
  localparam ftw_tach_st_t ST_RST = '{1'b1, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0};

  ftw_tach_st_t s_r;
  ftw_tach_st_t s_nxt;
  logic         rise;
  logic [3:0]   dv;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.tach_q = tach_in;
    rise = tach_in & ~s_r.tach_q;
    dv = 4'h1 << div_sel_in;
    if (rise) begin
      if (s_r.meas) begin
        s_nxt.res = s_r.cnt;
        s_nxt.done = 1'b1;
      end
      s_nxt.cnt = 8'h00;
      s_nxt.pre = 3'h0;
      s_nxt.meas = 1'b1;
    end else if (tick_in && s_r.meas) begin
      // Prescaling the base tick by the divisor gives the count law.
      if ({1'b0, s_r.pre} == dv - 4'h1) begin
        s_nxt.pre = 3'h0;
        if (s_r.cnt != 8'hFF) begin
          s_nxt.cnt = s_r.cnt + 8'h01;
        end
        if (s_r.cnt == 8'hFE) begin
          s_nxt.res = 8'hFF;
          s_nxt.done = 1'b1;
        end
      end else begin
        s_nxt.pre = s_r.pre + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count_out = s_r.res;
  assign done_out  = s_r.done;

  AST_TACH_SAT: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in) (s_r.cnt == 8'hFF && !rise) |=> s_r.cnt == 8'hFF)
    else $error("fan count left saturation without a tach edge");
  AST_TACH_RESTART: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in) rise |=> (s_r.cnt == 8'h00 && s_r.pre == 3'h0))
    else $error("fan count not restarted at period start");
endmodule

// file: ftw_top.sv
// Fan tachometer and temperature watchdog with two-wire register access.
module ftw_top #(
  // Upper device address bits; value is arbitrary.
  parameter logic [3:0] ADDR_HI       = 4'h5,
  parameter int         RST_PULSE_CYC = ftw_pkg::RST_PULSE_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  // Two-wire serial bus
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic [2:0]  addr_sel_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // Measurements
  input  wire logic        tach_input_first_in,
  input  wire logic        tach_input_second_in,
  input  wire logic [11:0] temp_sample_in,
  input  wire logic        temp_done_in,
  // Pins
  output logic             int_out,
  output logic             reset_or_overheat_pin_out
);
  localparam int TW = $clog2(ftw_pkg::TICK_CYC + 1);
  localparam int RW = $clog2(RST_PULSE_CYC + 1);

  if (RST_PULSE_CYC < 1) begin : g_chk
    $error("RST_PULSE_CYC must be at least one");
  end

  // ***************************************************************
  // State
  // ***************************************************************
  typedef enum logic [2:0] {
    B_IDLE, B_ADDR, B_AACK, B_WR, B_WACK, B_RD, B_RACK
  } ftw_bus_t;

  typedef struct packed {
    ftw_bus_t        st;
    logic            scl_q;
    logic            sda_q;
    logic [2:0]      bitn;
    logic            got;
    logic [7:0]      sh;
    logic            rw;
    logic            first;
    logic [7:0]      ptr;
    logic            sda_oe;
    logic [7:0]      ctl;
    logic [7:0]      isr1;
    logic [7:0]      isr2;
    logic [7:0]      fdiv;
    logic [7:0]      ocfg;
    logic [7:0]      hot;
    logic [7:0]      hoth;
    logic [7:0]      os;
    logic [7:0]      osh;
    logic [1:0][7:0] flim;
    logic [1:0][7:0] fan;
    logic [11:0]     temp;
    logic            hot_act;
    logic            hot_arm;
    logic            os_act;
    logic            os_arm;
    logic            os_low;
    logic [TW-1:0]   tcnt;
    logic            tick;
    logic [RW-1:0]   rcnt;
    logic            int_pin;
    logic            ro_pin;
  } ftw_st_t;

  function automatic ftw_st_t rst_val();
    ftw_st_t v;
    v = '0;
    v.st = B_IDLE;
    v.scl_q = 1'b1;
    v.sda_q = 1'b1;
    v.ctl = ftw_pkg::CTL_RST;
    v.fdiv = ftw_pkg::FDIV_RST;
    v.ocfg = ftw_pkg::OCFG_RST;
    v.hot = ftw_pkg::LIM_RST;
    v.hoth = ftw_pkg::LIM_RST;
    v.os = ftw_pkg::LIM_RST;
    v.osh = ftw_pkg::LIM_RST;
    v.flim = {ftw_pkg::FLIM_RST, ftw_pkg::FLIM_RST};
    v.hot_arm = 1'b1;
    v.os_arm = 1'b1;
    v.int_pin = 1'b1;
    v.ro_pin = 1'b1;
    return v;
  endfunction

  localparam ftw_st_t ST_RST = rst_val();

  ftw_st_t          s_r;
  ftw_st_t          s_nxt;

  function automatic logic [7:0] rd_byte(input ftw_st_t s,
                                         input logic    low_half);
    logic [7:0] v;
    v = 8'h00;
    case (s.ptr)
      ftw_pkg::A_CTL:   v = s.ctl;
      ftw_pkg::A_ISR1:  v = s.isr1;
      ftw_pkg::A_ISR2:  v = s.isr2;
      ftw_pkg::A_FDIV:  v = s.fdiv;
      ftw_pkg::A_OCFG:  v = {s.temp[3:0], s.ocfg[3:0]};
      // Second byte of a read here carries the low bits.
      ftw_pkg::A_TEMP:  v = low_half ? {s.temp[3:0], 4'h0}
                                    : s.temp[11:4];
      ftw_pkg::A_TACH_INPUT_FIRST:  v = s.fan[0];
      ftw_pkg::A_TACH_INPUT_SECOND:  v = s.fan[1];
      ftw_pkg::A_HOT:   v = s.hot;
      ftw_pkg::A_HOTH:  v = s.hoth;
      ftw_pkg::A_OS:    v = s.os;
      ftw_pkg::A_OSH:   v = s.osh;
      ftw_pkg::A_FLIM1: v = s.flim[0];
      ftw_pkg::A_FLIM2: v = s.flim[1];
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  // ***************************************************************
  // Fan counters
  // ***************************************************************
  logic [1:0][7:0] fcnt;
  logic [1:0]      fdone;
  logic [1:0]      tach;

  assign tach = {tach_input_second_in, tach_input_first_in};

  for (genvar gi = 0; gi < 2; gi++) begin : g_fan
    ftw_tach u_tach (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .tick_in    (s_r.tick),
      .tach_in    (tach[gi]),
      .div_sel_in (s_r.fdiv[ftw_pkg::FD_DIV0 + 2 * gi +: 2]),
      .count_out  (fcnt[gi]),
      .done_out   (fdone[gi])
    );
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  logic             rise;
  logic             fall;
  logic             start;
  logic             stop;
  logic             wr;
  logic             rc1;
  logic             rc2;
  logic [7:0]       rb;
  logic [7:0]       set1;
  logic [7:0]       set2;
  logic [7:0]       clr1;
  logic             run;
  logic             conv;
  logic [11:0]      samp;
  logic signed [7:0] deg;
  logic             above_hot;
  logic             below_hoth;
  logic             above_os;
  logic             below_osh;
  logic             hot_new;
  logic             os_new;
  logic             hot_set;
  logic             os_set;
  logic             act;

  always_comb begin
    s_nxt = s_r;
    wr = 1'b0;
    rc1 = 1'b0;
    rc2 = 1'b0;
    set1 = 8'h00;
    set2 = 8'h00;
    clr1 = 8'h00;
    hot_set = 1'b0;
    os_set = 1'b0;
    // The byte being loaded picks the half, so no stale flag is used.
    rb = rd_byte(s_r, s_r.st == B_RACK);
    s_nxt.scl_q = scl_in;
    s_nxt.sda_q = sda_in;
    rise = scl_in & ~s_r.scl_q;
    fall = ~scl_in & s_r.scl_q;
    start = scl_in & s_r.scl_q & s_r.sda_q & ~sda_in;
    stop = scl_in & s_r.scl_q & ~s_r.sda_q & sda_in;
    // Serial bus slave; no clock stretching, so timing is set by the host.
    if (start) begin
      s_nxt.st = B_ADDR;
      s_nxt.bitn = 3'h0;
      s_nxt.got = 1'b0;
      s_nxt.sda_oe = 1'b0;
    end else if (stop) begin
      s_nxt.st = B_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      unique case (s_r.st)
        B_IDLE: begin
        end
        B_ADDR, B_WR: begin
          if (rise) begin
            s_nxt.sh = {s_r.sh[6:0], sda_in};
            s_nxt.bitn = s_r.bitn + 3'h1;
            s_nxt.got = (s_r.bitn == 3'h7);
          end else if (fall && s_r.got) begin
            s_nxt.got = 1'b0;
            if (s_r.st == B_WR) begin
              s_nxt.sda_oe = 1'b1;
              s_nxt.st = B_WACK;
              s_nxt.first = 1'b0;
              if (s_r.first) begin
                s_nxt.ptr = s_r.sh;
              end else begin
                wr = 1'b1;
              end
            end else if (s_r.sh[7:1] == {ADDR_HI, addr_sel_in}) begin
              s_nxt.sda_oe = 1'b1;
              s_nxt.rw = s_r.sh[0];
              s_nxt.st = B_AACK;
            end else begin
              s_nxt.st = B_IDLE;
            end
          end
        end
        B_AACK, B_RACK: begin
          if (rise && s_r.st == B_RACK && sda_in) begin
            s_nxt.st = B_IDLE;
          end else if (fall) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.bitn = 3'h0;
            if (s_r.st == B_RACK || s_r.rw) begin
              s_nxt.sh = rb;
              s_nxt.sda_oe = ~rb[7];
              s_nxt.st = B_RD;
              rc1 = (s_r.ptr == ftw_pkg::A_ISR1);
              rc2 = (s_r.ptr == ftw_pkg::A_ISR2);
            end else begin
              s_nxt.first = 1'b1;
              s_nxt.st = B_WR;
            end
          end
        end
        B_WACK: begin
          if (fall) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.st = B_WR;
          end
        end
        B_RD: begin
          if (fall) begin
            if (s_r.bitn == 3'h7) begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.st = B_RACK;
            end else begin
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.sda_oe = ~s_r.sh[6];
              s_nxt.bitn = s_r.bitn + 3'h1;
            end
          end
        end
      endcase
    end
    // Register writes; status and temperature locations ignore writes.
    if (wr) begin
      case (s_r.ptr)
        ftw_pkg::A_CTL: begin
          s_nxt.ctl = {1'b0, s_r.sh[6:5], s_r.ctl[4], s_r.sh[3:0]};
          if (s_r.sh[ftw_pkg::CTL_RESET] && s_r.rcnt == '0 &&
              s_r.fdiv[ftw_pkg::FD_RSTEN] && !s_r.fdiv[ftw_pkg::FD_OSEN]) begin
            s_nxt.ctl[ftw_pkg::CTL_RESET] = 1'b1;
            s_nxt.rcnt = RW'(RST_PULSE_CYC);
          end
        end
        ftw_pkg::A_FDIV:  s_nxt.fdiv = s_r.sh;
        ftw_pkg::A_OCFG:  s_nxt.ocfg[3:0] = s_r.sh[3:0];
        ftw_pkg::A_HOT:   s_nxt.hot = s_r.sh;
        ftw_pkg::A_HOTH:  s_nxt.hoth = s_r.sh;
        ftw_pkg::A_OS:    s_nxt.os = s_r.sh;
        ftw_pkg::A_OSH:   s_nxt.osh = s_r.sh;
        ftw_pkg::A_FLIM1: s_nxt.flim[0] = s_r.sh;
        ftw_pkg::A_FLIM2: s_nxt.flim[1] = s_r.sh;
        default: begin
        end
      endcase
    end
    if (s_r.rcnt != '0) begin
      s_nxt.rcnt = s_r.rcnt - RW'(1);
      if (s_r.rcnt == RW'(1)) begin
        s_nxt.ctl[ftw_pkg::CTL_RESET] = 1'b0;
      end
    end
    // Base timebase tick for both fan counters.
    s_nxt.tick = 1'b0;
    s_nxt.tcnt = s_r.tcnt + TW'(1);
    if (s_r.tcnt == TW'(ftw_pkg::TICK_CYC - 1)) begin
      s_nxt.tcnt = '0;
      s_nxt.tick = 1'b1;
    end
    // Monitoring loop; halted while stopped or interrupt clear is set.
    run = s_r.ctl[ftw_pkg::CTL_START] & ~s_r.ctl[ftw_pkg::CTL_ICLR];
    conv = temp_done_in & run;
    samp = s_r.ocfg[ftw_pkg::OC_RES12] ? temp_sample_in
         : {temp_sample_in[11:3], 3'h0};
    deg = samp[11:4];
    above_hot = deg > $signed(s_r.hot);
    below_hoth = deg < $signed(s_r.hoth);
    above_os = deg > $signed(s_r.os);
    below_osh = deg < $signed(s_r.osh);
    hot_new = above_hot | (s_r.hot_act & ~below_hoth);
    os_new = above_os | (s_r.os_act & ~below_osh);
    if (conv) begin
      s_nxt.temp = samp;
      s_nxt.hot_act = hot_new;
      s_nxt.os_act = os_new;
      if (s_r.ocfg[ftw_pkg::OC_STAT1T]) begin
        hot_set = above_hot & s_r.hot_arm;
        os_set = above_os & s_r.os_arm;
        set2[ftw_pkg::ISR2_OS] = os_set;
      end else begin
        hot_set = hot_new;
        clr1[ftw_pkg::ISR1_HOT] = below_hoth;
        os_set = above_os & s_r.os_arm;
        set2[ftw_pkg::ISR2_OS] = os_new;
      end
      if (below_hoth) begin
        s_nxt.hot_arm = 1'b1;
      end
      if (hot_set) begin
        s_nxt.hot_arm = 1'b0;
      end
      if (below_osh) begin
        s_nxt.os_arm = 1'b1;
      end
      if (os_set) begin
        s_nxt.os_arm = 1'b0;
      end
    end
    set1[ftw_pkg::ISR1_HOT] = hot_set;
    // A read of the second status register releases a one-time low, but a new event wins.
    s_nxt.os_low = (s_r.os_low & ~rc2) | os_set;
    for (int i = 0; i < 2; i++) begin
      if (s_r.fdiv[ftw_pkg::FD_MODE0 + i]) begin
        set2[ftw_pkg::ISR2_FAN0 + i] = run & ~tach[i];
      end else if (fdone[i] && run) begin
        s_nxt.fan[i] = fcnt[i];
        set1[ftw_pkg::ISR1_FAN0 + i] = fcnt[i] > s_r.flim[i];
      end
    end
    // Set wins over a read clear in the same cycle.
    s_nxt.isr1 = ((rc1 ? 8'h00 : s_r.isr1) & ~clr1) | set1;
    s_nxt.isr2 = (rc2 ? 8'h00 : s_r.isr2) | set2;
    act = s_nxt.ctl[ftw_pkg::CTL_INTEN] & ~s_nxt.ctl[ftw_pkg::CTL_ICLR] &
          ((|s_nxt.isr1) | (|s_nxt.isr2));
    s_nxt.int_pin = s_nxt.ctl[ftw_pkg::CTL_POL] ? act : ~act;
    s_nxt.ro_pin = ~((s_nxt.fdiv[ftw_pkg::FD_RSTEN] &
                      ~s_nxt.fdiv[ftw_pkg::FD_OSEN] & (s_nxt.rcnt != '0)) |
                     (s_nxt.fdiv[ftw_pkg::FD_OSEN] &
                      ~s_nxt.fdiv[ftw_pkg::FD_RSTEN] &
                      ~s_nxt.ctl[ftw_pkg::CTL_ICLR] &
                      (s_nxt.ocfg[ftw_pkg::OC_OS1T] ? s_nxt.os_low
                                                    : s_nxt.os_act)));
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // The bus pin is open drain: only a low is ever driven.
  assign sda_out                   = 1'b0;
  assign sda_oe_out                = s_r.sda_oe;
  assign int_out                   = s_r.int_pin;
  assign reset_or_overheat_pin_out = s_r.ro_pin;

  // ***************************************************************
  // Checks
  // ***************************************************************
  AST_RES9: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (conv && !s_r.ocfg[ftw_pkg::OC_RES12]) |=> s_r.temp[2:0] == 3'h0)
    else $error("9-bit result carries invalid low bits");
  AST_ICLR: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    s_nxt.ctl[ftw_pkg::CTL_ICLR] |=> int_out == !s_r.ctl[ftw_pkg::CTL_POL])
    else $error("interrupt active while interrupt clear set");
  AST_HALT: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (s_r.ctl[ftw_pkg::CTL_ICLR] && temp_done_in) |=> $stable(s_r.temp))
    else $error("temperature updated while monitoring halted");
  AST_HOT_DEF: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (conv && above_hot && !s_r.ocfg[ftw_pkg::OC_STAT1T])
      |=> s_r.isr1[ftw_pkg::ISR1_HOT])
    else $error("over-hot reading did not set status");
  AST_ONETIME: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (conv && s_r.ocfg[ftw_pkg::OC_STAT1T] && !s_r.hot_arm)
      |=> !s_r.isr1[ftw_pkg::ISR1_HOT] || $past(s_r.isr1[ftw_pkg::ISR1_HOT]))
    else $error("one-time interrupt raised before hysteresis");
  AST_CMP_PIN: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (conv && above_os && !s_nxt.ocfg[ftw_pkg::OC_OS1T] &&
     s_nxt.fdiv[ftw_pkg::FD_OSEN] && !s_nxt.fdiv[ftw_pkg::FD_RSTEN])
      |=> !reset_or_overheat_pin_out)
    else $error("overheat pin not low above shutdown limit");
  AST_RDCLR: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (rc1 && set1 == 8'h00) |=> s_r.isr1 == 8'h00)
    else $error("status register not cleared by read");
endmodule

// file: ftw_host.sv
// Serial bus host model that reads and writes the block's registers.
module ftw_host (
  // Clock and bus
  input  wire logic  sys_clk_in,
  input  wire logic  sda_in,
  output logic       scl_out,
  output logic       sda_low_out,
  // Read data, one pulse per byte
  output logic [7:0] rd_out,
  output logic       rd_vld_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] DEV = 8'h54;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    rd_vld_out = 1'b0;
    rd_out = 8'h00;
  end
  // Four cycles keep each scl phase above the three-cycle minimum.
  task automatic wt();
    repeat (4) @(posedge sys_clk_in);
  endtask
  // A low p makes a start, a high p a stop.
  task automatic st(input logic p);
    wt();
    sda_low_out <= p;
    wt();
    scl_out <= 1'b1;
    wt();
    sda_low_out <= ~p;
    wt();
    scl_out <= p;
  endtask
  task automatic xb(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      wt();
      sda_low_out <= ~tx[i];
      wt();
      scl_out <= 1'b1;
      wt();
      rx[i] = sda_in;
      scl_out <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [8:0] r;
    st(1'b0);
    xb({DEV, 1'b1}, r);
    xb({a, 1'b1}, r);
    xb({d, 1'b1}, r);
    st(1'b1);
  endtask
  // The last byte is refused by the host so the device lets go.
  task automatic rd(input logic [7:0] a, input int n);
    logic [8:0] r;
    st(1'b0);
    xb({DEV, 1'b1}, r);
    xb({a, 1'b1}, r);
    st(1'b0);
    xb({DEV | 8'h01, 1'b1}, r);
    for (int k = 1; k <= n; k++) begin
      xb({8'hFF, k == n}, r);
      rd_out <= r[8:1];
      rd_vld_out <= 1'b1;
      @(posedge sys_clk_in);
      rd_vld_out <= 1'b0;
    end
    st(1'b1);
  endtask
endmodule

// file: testbench.sv
// Self-checking bench for the fan and temperature watchdog block.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [11:0] temp = 12'h000;
  logic        done = 1'b0;
  logic        tach1 = 1'b1;
  logic        tach2 = 1'b1;
  logic        scl, sda_low, sda_oe, vld, intn, pin;
  logic [7:0]  rdat;
  logic [7:0]  exp_q[$];
  logic [15:0] lfsr = 16'h3DEB;
  int          error_cnt = 0;
  int          check_count = 0;
  // The wire has a pull-up; either party may pull it low.
  wire         sda = ~(sda_low | sda_oe);
  localparam logic [31:0] LIM = 32'h19141E18;
  always #12.5 sys_clk_in = ~sys_clk_in;
  ftw_top #(.RST_PULSE_CYC(20)) uut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .scl_in(scl),
    .sda_in(sda), .addr_sel_in(3'h2), .sda_out(), .sda_oe_out(sda_oe),
    .tach_input_first_in(tach1), .tach_input_second_in(tach2),
    .temp_sample_in(temp), .temp_done_in(done), .int_out(intn),
    .reset_or_overheat_pin_out(pin));
  ftw_host host (.sys_clk_in(sys_clk_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low), .rd_out(rdat), .rd_vld_out(vld));
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  always @(posedge sys_clk_in) begin
    if (vld === 1'b1) begin
      check_count++;
      if (rdat !== exp_q.pop_front()) begin
        error_cnt++;
        $display("ERROR %0t read mismatch %h", $time, rdat);
      end
    end
  end
  task automatic rq(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a, 1);
  endtask
  task automatic cv(input logic [11:0] t);
    @(posedge sys_clk_in);
    temp <= t;
    done <= 1'b1;
    @(posedge sys_clk_in);
    done <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic ck(input logic a, input logic e);
    check_count++;
    if (a !== e) begin
      error_cnt++;
      $display("ERROR %0t pin mismatch", $time);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #2ms;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    ck(intn, 1'b1);
    rq(8'h00, 8'h08);
    rq(8'h05, 8'h14);
    for (int i = 0; i < 4; i++) rq(8'h38 + i[7:0], 8'h7F);
    for (int i = 0; i < 4; i++) begin
      lfsr = nx(lfsr);
      host.wr(8'h38 + i[7:0], lfsr[7:0]);
      rq(8'h38 + i[7:0], lfsr[7:0]);
      host.wr(8'h38 + i[7:0], LIM[31 - 8 * i -: 8]);
    end
    host.wr(8'h05, 8'h4C);
    rq(8'h05, 8'h4C);
    rq(8'h50, 8'h00);
    host.wr(8'h00, 8'h03);
    cv(12'h1A8);
    ck(intn, 1'b0);
    rq(8'h27, 8'h1A);
    rq(8'h06, 8'h80);
    exp_q.push_back(8'h1A);
    exp_q.push_back(8'h80);
    host.rd(8'h27, 2);
    ck(intn, 1'b0);
    rq(8'h01, 8'h10);
    ck(intn, 1'b1);
    cv(12'h1A8);
    ck(intn, 1'b0);
    cv(12'h130);
    ck(intn, 1'b1);
    host.wr(8'h06, 8'h08);
    cv(12'h1F5);
    rq(8'h27, 8'h1F);
    rq(8'h06, 8'h58);
    exp_q.push_back(8'h1F);
    exp_q.push_back(8'h50);
    host.rd(8'h27, 2);
    ck(pin, 1'b0);
    cv(12'h1C0);
    ck(pin, 1'b0);
    cv(12'h170);
    ck(pin, 1'b1);
    rq(8'h01, 8'h10);
    rq(8'h02, 8'h20);
    host.wr(8'h06, 8'h0A);
    cv(12'h100);
    cv(12'h1A0);
    ck(intn, 1'b0);
    rq(8'h01, 8'h10);
    cv(12'h1A0);
    ck(intn, 1'b1);
    cv(12'h100);
    cv(12'h1A0);
    ck(intn, 1'b0);
    host.wr(8'h00, 8'h0B);
    ck(intn, 1'b1);
    cv(12'h050);
    rq(8'h27, 8'h1A);
    rq(8'h01, 8'h10);
    host.wr(8'h00, 8'h03);
    host.wr(8'h06, 8'h0C);
    cv(12'h1F0);
    ck(pin, 1'b0);
    rq(8'h02, 8'h20);
    ck(pin, 1'b1);
    // Fan 2 runs at divisor 1; both tach edges sit midway between ticks,
    // so a period of three ticks must count exactly three.
    @(posedge sys_clk_in iff uut.s_r.tick);
    repeat (444) @(posedge sys_clk_in);
    tach2 <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    tach2 <= 1'b1;
    repeat (1332) @(posedge sys_clk_in);
    tach2 <= 1'b0;
    repeat (1332) @(posedge sys_clk_in);
    tach2 <= 1'b1;
    rq(8'h29, 8'h03);
    host.wr(8'h05, 8'h4D);
    tach1 <= 1'b0;
    rq(8'h02, 8'h04);
    final_report();
  end
endmodule
